// *** verilog/dcacd_pkg.sv ***
// Constants, register map and types of the panel auxiliary command decoder
package dcacd_pkg;
  // Wishbone byte offsets
  localparam logic [7:0] ADR_CMD    = 8'h00;
  localparam logic [7:0] ADR_PARAM  = 8'h04;
  localparam logic [7:0] ADR_STATUS = 8'h08;
  localparam logic [7:0] ADR_PINS   = 8'h0c;

  // Command codes
  localparam logic [7:0] CMD_SLEEP_IN    = 8'h10;
  localparam logic [7:0] CMD_SLEEP_OUT   = 8'h11;
  localparam logic [7:0] CMD_PCONF_SET   = 8'hb8;
  localparam logic [7:0] CMD_PCONF_GET   = 8'hb9;
  localparam logic [7:0] CMD_PVAL_SET    = 8'hba;
  localparam logic [7:0] CMD_PIN_STATUS  = 8'hbb;
  localparam logic [7:0] CMD_POST_SET    = 8'hbc;
  localparam logic [7:0] CMD_POST_GET    = 8'hbd;
  localparam logic [7:0] CMD_PWM_SET     = 8'hbe;
  localparam logic [7:0] CMD_PWM_GET     = 8'hbf;
  localparam logic [4:0] CMD_GEN_HI      = 5'h18;
  localparam logic [4:0] CMD_MAP_HI      = 5'h19;
  localparam logic [7:0] CMD_ABC_SET     = 8'hd0;
  localparam logic [7:0] CMD_ABC_GET     = 8'hd1;
  localparam logic [7:0] CMD_TH_SET      = 8'hd4;
  localparam logic [7:0] CMD_TH_GET      = 8'hd5;
  localparam logic [7:0] CMD_PLL_START   = 8'he0;
  localparam logic [7:0] CMD_PLL_SET     = 8'he2;
  localparam logic [7:0] CMD_PLL_GET     = 8'he3;
  localparam logic [7:0] CMD_PLL_STATUS  = 8'he4;
  localparam logic [7:0] CMD_DEEP_SLEEP  = 8'he5;
  localparam logic [7:0] CMD_PCLK_SET    = 8'he6;
  localparam logic [7:0] CMD_PCLK_GET    = 8'he7;
  localparam logic [7:0] CMD_PIXIF_SET   = 8'hf0;
  localparam logic [7:0] CMD_PIXIF_GET   = 8'hf1;

  // Parameter store: slots of eight bytes
  localparam int         NUM_PINS   = 4;
  localparam int         NUM_GENS   = 4;
  localparam int         NUM_SLOTS  = 18;
  localparam int         SLOT_BYTES = 8;
  localparam int         MEM_BYTES  = NUM_SLOTS * SLOT_BYTES;
  localparam logic [4:0] SLOT_PCONF = 5'd0;
  localparam logic [4:0] SLOT_PVAL  = 5'd1;
  localparam logic [4:0] SLOT_POST  = 5'd2;
  localparam logic [4:0] SLOT_PWM   = 5'd3;
  localparam logic [4:0] SLOT_GEN0  = 5'd4;
  localparam logic [4:0] SLOT_MAP0  = 5'd8;
  localparam logic [4:0] SLOT_ABC   = 5'd12;
  localparam logic [4:0] SLOT_TH    = 5'd13;
  localparam logic [4:0] SLOT_PLL   = 5'd14;
  localparam logic [4:0] SLOT_PCLK  = 5'd15;
  localparam logic [4:0] SLOT_PIXIF = 5'd16;
  localparam logic [4:0] SLOT_START = 5'd17;

  // Byte positions inside the store
  localparam int MA_PIN_PANEL = 0;
  localparam int MA_PIN_DIR   = 1;
  localparam int MA_PIN_VAL   = 8;
  localparam int MA_PWM_DIV   = 24;
  localparam int MA_PWM_DUTY  = 25;
  localparam int MA_PWM_EN    = 26;
  localparam int MA_GEN0      = 32;
  localparam int MA_MAP0      = 64;
  localparam int MA_PIX_FMT   = 128;
  localparam int MA_START     = 136;
  // Field offsets within a waveform generator slot
  localparam int GEN_PER_LO  = 0;
  localparam int GEN_PER_HI  = 1;
  localparam int GEN_RISE_LO = 2;
  localparam int GEN_RISE_HI = 3;
  localparam int GEN_FALL_LO = 4;
  localparam int GEN_FALL_HI = 5;
  localparam int GEN_MODE    = 6;
  localparam int GEN_W       = 12;
  localparam int GEN_MODE_EN  = 0;
  localparam int GEN_MODE_TOG = 1;
  // Pin logic map slot: byte 0 truth table, byte 1 operand selects
  localparam int MAP_CODE = 0;
  localparam int MAP_SEL  = 1;
  // Start byte bits
  localparam int START_EN   = 0;
  localparam int START_LOCK = 1;
  // Host pixel format that carries 5-6-5 words
  localparam logic [2:0] PIX_FMT_565 = 3'h3;

  // Reset values
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic        RST_SLEEP = 1'b0;
  localparam logic [17:0] RST_RGB   = 18'h00000;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b001,
    PH_SET  = 3'b010,
    PH_GET  = 3'b100
  } dcacd_phase_t;
endpackage

// *** verilog/dcacd_wave_gen.sv ***
// Periodic waveform generator with rise, fall and toggle mode
`timescale 1ns/1ps
`default_nettype none
module dcacd_wave_gen (
  input  wire logic                      mclk,
  input  wire logic                      rst_n,
  input  wire logic [dcacd_pkg::GEN_W-1:0] period,
  input  wire logic [dcacd_pkg::GEN_W-1:0] rise,
  input  wire logic [dcacd_pkg::GEN_W-1:0] fall,
  input  wire logic [1:0]                mode,
  output logic                           wave
);
  logic [dcacd_pkg::GEN_W-1:0] cnt_r;
  logic [dcacd_pkg::GEN_W-1:0] cnt_nxt;
  wire                         at_end = (cnt_r >= period);

  assign cnt_nxt = at_end ? '0 : cnt_r + 1'b1;

  // Disabled generator parks low so a mapped pin sees a stable operand
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      wave  <= 1'b0;
    end else if (!mode[dcacd_pkg::GEN_MODE_EN]) begin
      cnt_r <= '0;
      wave  <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      if (mode[dcacd_pkg::GEN_MODE_TOG]) begin
        if (cnt_r == rise) begin
          wave <= ~wave;
        end
      end else begin
        wave <= (cnt_r >= rise) && (cnt_r < fall);
      end
    end
  end
endmodule // dcacd_wave_gen
`default_nettype wire

// *** verilog/dcacd_pin_map.sv ***
// Three-operand raster operation over the generator outputs
`timescale 1ns/1ps
`default_nettype none
module dcacd_pin_map (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [3:0] gens,
  input  wire logic [7:0] code,
  input  wire logic [7:0] sel,
  output logic            pin
);
  wire op_a = gens[sel[1:0]];
  wire op_b = gens[sel[3:2]];
  wire op_c = gens[sel[5:4]];
  wire res  = code[{op_a, op_b, op_c}];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin <= 1'b0;
    end else begin
      pin <= res;
    end
  end
endmodule // dcacd_pin_map
`default_nettype wire

// *** verilog/dcacd_top.sv ***
// Panel auxiliary command decoder with Wishbone register access
// Functional notes
// - Pin config: panel pins follow generators, others direction
// - Pin config read returns configuration in force
// - Pin value write sets levels of output pins
// - Pin status: inputs show live level, others programmed
// - Post-processor and PWM set/get each decoded
// - Four waveform generators, each with own set
// - Each generator has matching settings read
// - Per-pin three-operand raster op over generators
// - Raster map write ignored on plain pins
// - Per-pin raster map read returns programmed map
// - Adaptive backlight configuration set and read
// - Backlight threshold levels set and read
// - Crystal clock until PLL start sets both enable and lock bits, then PLL
// - PLL multiplier/divider set and read back
// - PLL status read returns live lock state
// - Pixel clock frequency set and read back
// - Host pixel format set and read back
// - Sleep commands drive pin zero only unconfigured
`timescale 1ns/1ps
`default_nettype none
module dcacd_top (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [3:0]  pin_in,
  output logic      [3:0]  pin_out,
  output logic      [3:0]  pin_oe,
  input  wire logic        pll_lock,
  output logic             pll_en,
  output logic             sys_clk_pll,
  output logic             deep_sleep,
  output logic             bl_pwm,
  input  wire logic [17:0] host_pix,
  input  wire logic        host_pix_vld,
  output logic      [17:0] panel_rgb
);
  // Reset release through two flops; assertion stays asynchronous
  logic rst_meta_r;
  logic rst_n;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  // Pin and lock inputs come from outside: two flops first
  logic [3:0] pin_meta_r;
  logic [3:0] pin_sync_r;
  logic       lock_meta_r;
  logic       lock_sync_r;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_r  <= '0;
      pin_sync_r  <= '0;
      lock_meta_r <= 1'b0;
      lock_sync_r <= 1'b0;
    end else begin
      pin_meta_r  <= pin_in;
      pin_sync_r  <= pin_meta_r;
      lock_meta_r <= pll_lock;
      lock_sync_r <= lock_meta_r;
    end
  end

  // Bus decode
  logic                  ack_r;
  logic [31:0]           dat_r;
  logic [7:0]            cmd_r;
  logic [4:0]            slot_r;
  logic [3:0]            idx_r;
  dcacd_pkg::dcacd_phase_t phase_r;
  logic [7:0]            mem_r [dcacd_pkg::MEM_BYTES];

  wire       req       = wb_cyc_i & wb_stb_i & ~ack_r;
  wire       wr        = req & wb_we_i & wb_sel_i[0];
  wire       rd        = req & ~wb_we_i;
  wire [7:0] off       = {wb_adr_i[7:2], 2'b00};
  wire       hit_cmd   = (off == dcacd_pkg::ADR_CMD);
  wire       hit_param = (off == dcacd_pkg::ADR_PARAM);
  wire       hit_stat  = (off == dcacd_pkg::ADR_STATUS);
  wire       hit_pins  = (off == dcacd_pkg::ADR_PINS);
  wire [7:0] wbyte     = wb_dat_i[7:0];
  wire       cmd_wr    = wr & hit_cmd;
  wire       room      = ~idx_r[3];

  // Command to {valid, is_get, slot}
  function automatic logic [6:0] cmd_dec(input logic [7:0] c);
    logic [6:0] d;
    d = '0;
    case (c)
      dcacd_pkg::CMD_PCONF_SET:  d = {2'b10, dcacd_pkg::SLOT_PCONF};
      dcacd_pkg::CMD_PCONF_GET:  d = {2'b11, dcacd_pkg::SLOT_PCONF};
      dcacd_pkg::CMD_PVAL_SET:   d = {2'b10, dcacd_pkg::SLOT_PVAL};
      dcacd_pkg::CMD_PIN_STATUS: d = {2'b11, dcacd_pkg::SLOT_PVAL};
      dcacd_pkg::CMD_POST_SET:   d = {2'b10, dcacd_pkg::SLOT_POST};
      dcacd_pkg::CMD_POST_GET:   d = {2'b11, dcacd_pkg::SLOT_POST};
      dcacd_pkg::CMD_PWM_SET:    d = {2'b10, dcacd_pkg::SLOT_PWM};
      dcacd_pkg::CMD_PWM_GET:    d = {2'b11, dcacd_pkg::SLOT_PWM};
      dcacd_pkg::CMD_ABC_SET:    d = {2'b10, dcacd_pkg::SLOT_ABC};
      dcacd_pkg::CMD_ABC_GET:    d = {2'b11, dcacd_pkg::SLOT_ABC};
      dcacd_pkg::CMD_TH_SET:     d = {2'b10, dcacd_pkg::SLOT_TH};
      dcacd_pkg::CMD_TH_GET:     d = {2'b11, dcacd_pkg::SLOT_TH};
      dcacd_pkg::CMD_PLL_START:  d = {2'b10, dcacd_pkg::SLOT_START};
      dcacd_pkg::CMD_PLL_SET:    d = {2'b10, dcacd_pkg::SLOT_PLL};
      dcacd_pkg::CMD_PLL_GET:    d = {2'b11, dcacd_pkg::SLOT_PLL};
      dcacd_pkg::CMD_PLL_STATUS: d = {2'b11, dcacd_pkg::SLOT_START};
      dcacd_pkg::CMD_PCLK_SET:   d = {2'b10, dcacd_pkg::SLOT_PCLK};
      dcacd_pkg::CMD_PCLK_GET:   d = {2'b11, dcacd_pkg::SLOT_PCLK};
      dcacd_pkg::CMD_PIXIF_SET:  d = {2'b10, dcacd_pkg::SLOT_PIXIF};
      dcacd_pkg::CMD_PIXIF_GET:  d = {2'b11, dcacd_pkg::SLOT_PIXIF};
      default: begin
        if (c[7:3] == dcacd_pkg::CMD_GEN_HI) begin
          d = {1'b1, c[0], dcacd_pkg::SLOT_GEN0 + {3'b000, c[2:1]}};
        end else if (c[7:3] == dcacd_pkg::CMD_MAP_HI) begin
          d = {1'b1, c[0], dcacd_pkg::SLOT_MAP0 + {3'b000, c[2:1]}};
        end
      end
    endcase
    return d;
  endfunction

  wire [6:0] dec       = cmd_dec(wbyte);
  wire [7:0] maddr     = {slot_r, idx_r[2:0]};
  wire [3:0] panel_msk = mem_r[dcacd_pkg::MA_PIN_PANEL][3:0];
  wire [3:0] dir_msk   = mem_r[dcacd_pkg::MA_PIN_DIR][3:0];
  wire [3:0] val_msk   = mem_r[dcacd_pkg::MA_PIN_VAL][3:0];
  wire       is_map    = (slot_r[4:2] == 3'b010);
  wire       map_block = is_map & ~panel_msk[slot_r[1:0]];
  wire       pset      = wr & hit_param & (phase_r == dcacd_pkg::PH_SET)
                         & room & ~map_block;
  wire       pget      = rd & hit_param & (phase_r == dcacd_pkg::PH_GET)
                         & room;
  wire       start_wr  = pset & (slot_r == dcacd_pkg::SLOT_START);

  // Command phase and byte index
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_r   <= dcacd_pkg::RST_BYTE;
      slot_r  <= '0;
      idx_r   <= '0;
      phase_r <= dcacd_pkg::PH_IDLE;
    end else if (cmd_wr) begin
      cmd_r  <= wbyte;
      slot_r <= dec[4:0];
      idx_r  <= '0;
      case ({dec[6], dec[5]})
        2'b10:   phase_r <= dcacd_pkg::PH_SET;
        2'b11:   phase_r <= dcacd_pkg::PH_GET;
        default: phase_r <= dcacd_pkg::PH_IDLE;
      endcase
    end else if (pset || pget) begin
      idx_r <= idx_r + 4'h1;
    end
  end

  // Parameter store; a get reads back what the set left, except byte 0 of pin status and PLL status
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < dcacd_pkg::MEM_BYTES; i++) begin
        mem_r[i] <= dcacd_pkg::RST_BYTE;
      end
    end else if (pset) begin
      mem_r[maddr] <= wbyte;
    end
  end

  // Pin zero stays under sleep control until pins are configured
  logic conf_done_r;
  logic sleep_lvl_r;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      conf_done_r <= 1'b0;
      sleep_lvl_r <= dcacd_pkg::RST_SLEEP;
    end else begin
      if (pset && slot_r == dcacd_pkg::SLOT_PCONF) begin
        conf_done_r <= 1'b1;
      end
      if (cmd_wr && !conf_done_r) begin
        if (wbyte == dcacd_pkg::CMD_SLEEP_IN) begin
          sleep_lvl_r <= 1'b0;
        end else if (wbyte == dcacd_pkg::CMD_SLEEP_OUT) begin
          sleep_lvl_r <= 1'b1;
        end
      end
    end
  end

  // Clocking and sleep state
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pll_en      <= 1'b0;
      sys_clk_pll <= 1'b0;
      deep_sleep  <= 1'b0;
    end else begin
      if (start_wr && idx_r == 4'h0) begin
        pll_en      <= wbyte[dcacd_pkg::START_EN];
        sys_clk_pll <= wbyte[dcacd_pkg::START_EN]
                       & wbyte[dcacd_pkg::START_LOCK];
      end
      if (cmd_wr) begin
        deep_sleep <= (wbyte == dcacd_pkg::CMD_DEEP_SLEEP);
      end
    end
  end

  // Waveform generators and per-pin maps
  logic [3:0] gen_o;
  logic [3:0] map_o;
  for (genvar g = 0; g < dcacd_pkg::NUM_GENS; g++) begin : g_gen
    localparam int B = dcacd_pkg::MA_GEN0 + g * dcacd_pkg::SLOT_BYTES;
    localparam int M = dcacd_pkg::MA_MAP0 + g * dcacd_pkg::SLOT_BYTES;
    dcacd_wave_gen u_gen (
      .mclk   (mclk),
      .rst_n  (rst_n),
      .period ({mem_r[B + dcacd_pkg::GEN_PER_HI][3:0],
                mem_r[B + dcacd_pkg::GEN_PER_LO]}),
      .rise   ({mem_r[B + dcacd_pkg::GEN_RISE_HI][3:0],
                mem_r[B + dcacd_pkg::GEN_RISE_LO]}),
      .fall   ({mem_r[B + dcacd_pkg::GEN_FALL_HI][3:0],
                mem_r[B + dcacd_pkg::GEN_FALL_LO]}),
      .mode   (mem_r[B + dcacd_pkg::GEN_MODE][1:0]),
      .wave   (gen_o[g])
    );
    dcacd_pin_map u_map (
      .mclk (mclk),
      .rst_n(rst_n),
      .gens (gen_o),
      .code (mem_r[M + dcacd_pkg::MAP_CODE]),
      .sel  (mem_r[M + dcacd_pkg::MAP_SEL]),
      .pin  (map_o[g])
    );
  end

  // Backlight PWM reuses the generator: high from zero to duty
  logic pwm_wave;
  dcacd_wave_gen u_pwm (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .period ({4'h0, mem_r[dcacd_pkg::MA_PWM_DIV]}),
    .rise   ('0),
    .fall   ({4'h0, mem_r[dcacd_pkg::MA_PWM_DUTY]}),
    .mode   ({1'b0, mem_r[dcacd_pkg::MA_PWM_EN][0]}),
    .wave   (pwm_wave)
  );

  // Pin drive
  logic [3:0] pin_nxt;
  logic [3:0] oe_nxt;
  always_comb begin
    for (int i = 0; i < dcacd_pkg::NUM_PINS; i++) begin
      pin_nxt[i] = panel_msk[i] ? map_o[i] : val_msk[i];
      oe_nxt[i]  = panel_msk[i] | dir_msk[i];
    end
    if (!conf_done_r) begin
      pin_nxt[0] = sleep_lvl_r;
      oe_nxt[0]  = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out <= '0;
      pin_oe  <= '0;
      bl_pwm  <= 1'b0;
    end else begin
      pin_out <= pin_nxt;
      pin_oe  <= oe_nxt;
      bl_pwm  <= pwm_wave;
    end
  end

  // Host pixel to panel colour; 5-bit fields replicate their MSB
  wire [2:0]  pix_fmt = mem_r[dcacd_pkg::MA_PIX_FMT][2:0];
  wire [17:0] rgb_565 = {host_pix[15:11], host_pix[15],
                         host_pix[10:5],
                         host_pix[4:0], host_pix[4]};
  wire [17:0] rgb_nxt = (pix_fmt == dcacd_pkg::PIX_FMT_565) ?
                        rgb_565 : host_pix;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      panel_rgb <= dcacd_pkg::RST_RGB;
    end else if (host_pix_vld) begin
      panel_rgb <= rgb_nxt;
    end
  end

  // Answer bytes
  logic [3:0] stat_msk;
  always_comb begin
    for (int i = 0; i < dcacd_pkg::NUM_PINS; i++) begin
      stat_msk[i] = (~panel_msk[i] & ~dir_msk[i]) ?
                    pin_sync_r[i] : val_msk[i];
    end
  end

  wire first   = (idx_r == 4'h0);
  wire is_pst  = (cmd_r == dcacd_pkg::CMD_PIN_STATUS) & first;
  wire is_lst  = (cmd_r == dcacd_pkg::CMD_PLL_STATUS) & first;
  wire [7:0] resp = is_pst ? {4'h0, stat_msk} :
                    is_lst ? {7'h00, lock_sync_r} :
                    mem_r[maddr];
  wire [7:0] pbyte = (phase_r == dcacd_pkg::PH_GET && room) ?
                     resp : dcacd_pkg::RST_BYTE;
  wire [31:0] stat_w = {20'h00000, phase_r, idx_r, deep_sleep,
                        sys_clk_pll, pll_en, lock_sync_r,
                        conf_done_r};
  wire [31:0] pins_w = {20'h00000, pin_oe, pin_out, pin_sync_r};
  wire [31:0] rd_w   = hit_cmd   ? {24'h000000, cmd_r} :
                       hit_param ? {24'h000000, pbyte} :
                       hit_stat  ? stat_w :
                       hit_pins  ? pins_w : 32'h00000000;

  // Single-wait classic slave: ack one cycle after the strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      dat_r <= '0;
    end else begin
      ack_r <= req;
      if (rd) begin
        dat_r <= rd_w;
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
endmodule // dcacd_top
`default_nettype wire

// *** verification/dcacd_properties.sv ***
// Concurrent checks on the ports of the auxiliary command decoder
`timescale 1ns/1ps
`default_nettype none
module dcacd_properties (
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [3:0]  pin_out,
  input wire logic [3:0]  pin_oe,
  input wire logic        pll_en,
  input wire logic        sys_clk_pll,
  input wire logic [17:0] host_pix,
  input wire logic        host_pix_vld,
  input wire logic [17:0] panel_rgb
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  wire logic rd_ack = wb_ack_o && !wb_we_i;

  // Host format in force, followed from the bus so the expected word fits it
  logic fmt_cmd_r;
  logic fmt565_r;
  wire logic take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fmt_cmd_r <= 1'b0;
      fmt565_r  <= 1'b0;
    end else if (take && wb_adr_i == dcacd_pkg::ADR_CMD) begin
      fmt_cmd_r <= (wb_dat_i[7:0] == dcacd_pkg::CMD_PIXIF_SET);
    end else if (take && wb_adr_i == dcacd_pkg::ADR_PARAM && fmt_cmd_r) begin
      fmt565_r  <= (wb_dat_i[2:0] == dcacd_pkg::PIX_FMT_565);
      fmt_cmd_r <= 1'b0;
    end
  end
  wire logic [17:0] pix_exp = fmt565_r ? {host_pix[15:11], host_pix[15],
    host_pix[10:5], host_pix[4:0], host_pix[4]} : host_pix;

  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_timely: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o)
    else $error("request not answered in the next cycle");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  a_clk_source: assert property (sys_clk_pll |-> pll_en)
    else $error("system on pll clock while pll disabled");
  a_pix_capture: assert property (host_pix_vld
    |=> panel_rgb == $past(pix_exp))
    else $error("panel word differs from host word");
  a_rgb_hold: assert property (!host_pix_vld |=> $stable(panel_rgb))
    else $error("panel word changed without a strobe");
  a_status_phase: assert property (rd_ack && wb_adr_i == dcacd_pkg::ADR_STATUS
    |-> $onehot(wb_dat_o[11:9]))
    else $error("status phase not one-hot");
  a_unmapped_zero: assert property (rd_ack && wb_adr_i[7:4] != 4'h0
    |-> wb_dat_o == 32'h00000000)
    else $error("unmapped read not zero");
  a_pins_view: assert property (rd_ack && wb_adr_i == dcacd_pkg::ADR_PINS
    |-> wb_dat_o[11:4] == $past({pin_oe, pin_out}))
    else $error("pin view differs from pin outputs");
endmodule // dcacd_properties

bind dcacd_top dcacd_properties u_props (
  .mclk(mclk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .pin_out(pin_out), .pin_oe(pin_oe),
  .pll_en(pll_en), .sys_clk_pll(sys_clk_pll), .host_pix(host_pix),
  .host_pix_vld(host_pix_vld), .panel_rgb(panel_rgb)
);
`default_nettype wire

// *** verification/dcacd_pin_world.sv ***
// Pin and PLL surroundings of the decoder: outside levels and lock
`timescale 1ns/1ps
`default_nettype none
module dcacd_pin_world (
  input  wire logic       mclk,
  input  wire logic [3:0] pin_out,
  input  wire logic [3:0] pin_oe,
  input  wire logic [3:0] ext_lvl,
  input  wire logic       pll_en,
  output logic      [3:0] pin_in,
  output logic            pll_lock
);
  logic [4:0] lock_cnt_r = 5'h00;
  // A driven pin reads back its own level, a released one the outside level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
  // Lock goes high 16 cycles after enable, before the bench reads the status
  always_ff @(posedge mclk) begin
    if (!pll_en) lock_cnt_r <= 5'h00;
    else if (lock_cnt_r != 5'h10) lock_cnt_r <= lock_cnt_r + 5'h01;
  end
  assign pll_lock = (lock_cnt_r == 5'h10);
endmodule // dcacd_pin_world
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking bench for the auxiliary command decoder
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic             mclk = 1'b0;
  logic             rst_b = 1'b0;
  logic             cyc = 1'b0;
  logic             stb = 1'b0;
  logic             we = 1'b0;
  logic [7:0]       adr = 8'h00;
  logic [31:0]      wdat = 32'h00000000;
  logic [31:0]      rdat;
  logic [3:0]       ext_lvl = 4'ha;
  logic [17:0]      pix = 18'h00000;
  logic             pix_vld = 1'b0;
  logic [63:0]      got;
  wire logic [31:0] dat_o;
  wire logic        ack, pll_lock, pll_en, clk_pll;
  wire logic        dsl, pwm;
  int               hits = 0;
  wire logic [3:0]  pin_in, pin_out, pin_oe;
  wire logic [17:0] rgb;
  int               fail_count = 0;
  int               samples_checked = 0;
  logic [7:0]       codes [11] = '{8'hbc, 8'hbe, 8'hc0, 8'hc2, 8'hc4, 8'hc6,
                                   8'hd0, 8'hd4, 8'he2, 8'he6, 8'hf0};
  logic [17:0]      cols [4] = '{18'h3f000, 18'h00fc0, 18'h0003f, 18'h3ffff};

  always #25 mclk = ~mclk;

  dcacd_top uut (
    .mclk(mclk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pll_lock(pll_lock), .pll_en(pll_en),
    .sys_clk_pll(clk_pll), .deep_sleep(dsl), .bl_pwm(pwm), .host_pix(pix),
    .host_pix_vld(pix_vld), .panel_rgb(rgb)
  );
  dcacd_pin_world u_world (
    .mclk(mclk), .pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl),
    .pll_en(pll_en), .pin_in(pin_in), .pll_lock(pll_lock)
  );

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Holds the request until ack is sampled, then releases at that edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    // A hung slave is ended by the watchdog, not here
    do begin
      @(posedge mclk);
    end while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic put(input logic [7:0] code, input logic [63:0] d);
    wb(1'b1, dcacd_pkg::ADR_CMD, code);
    for (int k = 0; k < 8; k++) wb(1'b1, dcacd_pkg::ADR_PARAM, d[8*k +: 8]);
  endtask

  task automatic get(input logic [7:0] code);
    wb(1'b1, dcacd_pkg::ADR_CMD, code);
    for (int k = 0; k < 8; k++) begin
      wb(1'b0, dcacd_pkg::ADR_PARAM, 8'h00);
      got[8*k +: 8] = rdat[7:0];
    end
  endtask

  // High cycles over eight edges of the PWM or of pin zero
  task automatic hi8(input logic pick);
    hits = 0;
    repeat (8) begin
      @(posedge mclk);
      hits += pick ? pwm : pin_out[0];
    end
  endtask

  task automatic pins();
    repeat (6) @(posedge mclk);
    wb(1'b0, dcacd_pkg::ADR_PINS, 8'h00);
  endtask

  initial begin
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    wb(1'b1, dcacd_pkg::ADR_CMD, dcacd_pkg::CMD_SLEEP_OUT);
    pins();
    chk({rdat[8], rdat[4]}, 2'b11);
    wb(1'b1, dcacd_pkg::ADR_CMD, dcacd_pkg::CMD_SLEEP_IN);
    pins();
    chk({rdat[8], rdat[4]}, 2'b10);
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      pix <= cols[i];
      pix_vld <= 1'b1;
      @(posedge mclk);
      pix_vld <= 1'b0;
      @(posedge mclk);
      chk(rgb, cols[i]);
    end
    // Pins 0 and 1 outputs, 2 and 3 inputs, none on the panel
    put(dcacd_pkg::CMD_PCONF_SET, 64'h0300);
    put(dcacd_pkg::CMD_PVAL_SET, 64'h05);
    pins();
    chk({rdat[11:8], rdat[5:0]}, {4'h3, 2'b01, 4'h9});
    get(dcacd_pkg::CMD_PIN_STATUS);
    chk(got[3:0], 4'h9);
    get(dcacd_pkg::CMD_PCONF_GET);
    chk(got[15:0], 16'h0300);
    wb(1'b1, dcacd_pkg::ADR_CMD, dcacd_pkg::CMD_SLEEP_IN);
    pins();
    chk(rdat[4], 1'b1);
    put(8'hc8, 64'h00aa);
    get(8'hc9);
    chk(got[15:0], 16'h0000);
    put(dcacd_pkg::CMD_PCONF_SET, 64'h0301);
    put(8'hc8, 64'h00ff);
    get(8'hc9);
    chk(got[15:0], 16'h00ff);
    pins();
    chk({rdat[8], rdat[4]}, 2'b11);
    put(8'hc8, 64'h0000);
    pins();
    chk({rdat[8], rdat[4]}, 2'b10);
    for (int j = 0; j < 11; j++) begin
      put(codes[j], {8{4'h0, 4'(j)}} + 64'h0706050403020100);
      get(codes[j] + 8'h01);
      chk(got, {8{4'h0, 4'(j)}} + 64'h0706050403020100);
    end
    // Generator 0: period 3, high from 1 to 3, mapped onto panel pin 0
    put(8'hc0, 64'h0001000300010003);
    put(8'hc8, 64'h00f0);
    hi8(1'b0);
    chk(hits, 4);
    put(dcacd_pkg::CMD_PWM_SET, 64'h010103);
    hi8(1'b1);
    chk(hits, 2);
    wb(1'b1, dcacd_pkg::ADR_CMD, dcacd_pkg::CMD_DEEP_SLEEP);
    wb(1'b0, dcacd_pkg::ADR_STATUS, 8'h00);
    chk({dsl, rdat[4]}, 2'b11);
    put(dcacd_pkg::CMD_PIXIF_SET, 64'h03);
    chk(dsl, 1'b0);
    @(posedge mclk);
    pix <= 18'h0ffff;
    pix_vld <= 1'b1;
    @(posedge mclk);
    pix_vld <= 1'b0;
    @(posedge mclk);
    chk(rgb, 18'h3ffff);
    put(dcacd_pkg::CMD_PLL_START, 64'h01);
    repeat (30) @(posedge mclk);
    get(dcacd_pkg::CMD_PLL_STATUS);
    chk(got[0], 1'b1);
    chk(clk_pll, 1'b0);
    put(dcacd_pkg::CMD_PLL_START, 64'h03);
    wb(1'b0, dcacd_pkg::ADR_STATUS, 8'h00);
    chk(rdat[3:1], 3'b111);
    wb(1'b1, 8'h10, 8'hff);
    wb(1'b0, 8'h10, 8'h00);
    chk(rdat, 32'h00000000);
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    stop_test();
  end
endmodule // tb
`default_nettype wire
